/* hdl/cscru_top.sv */
// clock select, slow divider, watchdog, periodic interrupt and monitor
// --------------------------------------------------------------------
// --------------------------------------------------------------------
//
// Chosen here: the APB register port.
module cscru_top
  import cscru_pkg::*;
#(
  parameter int CM_CYC = CSCRU_CM_CYC
)(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // clock sources as enables
  input  wire logic        xtal_en,
  input  wire logic        pll_en,
  input  wire logic        pll_locked,
  input  wire logic        pll_supply_good,
  input  wire logic        special_mode,
  input  wire logic        cpu_in_wait,
  // status
  output cscru_clk_s       clk_en,
  output logic             clk_select_ok,
  output logic             limp_home,
  output logic             pll_sel_eff,
  output logic             mcs_eff,
  output logic             pll_bw_low,
  output logic             osc_keep_in_stop,
  output logic             limp_irq,
  output logic             periodic_irq,
  output logic             part_reset
);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [7:0] realtime_interrupt_control_r, copctl_r, pllcr_r, clock_source_select_r, slow_r;
  logic       periodic_irq_flag_r, nolh_wr_r, swai_wr_r, wcop_wr_r;
  logic       svc_armed_r, lh_flag_r;
  logic       wr, rd;
  logic [7:0] wb;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign wb = pwdata[7:0];

  function automatic logic hit(input logic [11:0] a, input logic [11:0] i);
    // register indices become byte addresses, one aligned word each
    hit = (a == {i[9:0], 2'b00});
  endfunction : hit

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
    end
  end

  // pllcr: supply forces and limp-home disable, write-once outside special mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pllcr_r   <= CSCRU_PLLCR_RST;
      nolh_wr_r <= 1'b0;
    end else if (!pll_supply_good) begin
      pllcr_r[CSCRU_LIMP_HOME_IRQ_ENABLE_BIT]  <= 1'b0;
      pllcr_r[CSCRU_NOLH_BIT]  <= 1'b1;
      pllcr_r[CSCRU_PLL_POWER_ON_BIT] <= 1'b0;
    end else if (wr && pready && hit(paddr, CSCRU_PLLCR_IDX)) begin
      pllcr_r[7:1] <= {wb[7], (wb[6] | clock_source_select_r[CSCRU_PLL_SELECT_BIT]), wb[5],
                       (wb[5] ? pllcr_r[CSCRU_ACQ_BIT] : wb[4]), 1'b0,
                       wb[2], wb[1]};
      if (special_mode || !nolh_wr_r) begin
        pllcr_r[CSCRU_NOLH_BIT] <= wb[0];
        nolh_wr_r <= 1'b1;
      end
    end else if (pllcr_r[CSCRU_AUTO_BIT]) begin
      pllcr_r[CSCRU_ACQ_BIT] <= pll_locked;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_source_select_r <= 8'h00;
      slow_r   <= 8'h00;
    end else if (wr && pready) begin
      if (hit(paddr, CSCRU_CLOCK_SOURCE_SELECT_IDX)) begin
        clock_source_select_r <= wb & 8'h67;
        if (!pllcr_r[CSCRU_PLL_POWER_ON_BIT])
          clock_source_select_r[CSCRU_PLL_SELECT_BIT] <= 1'b0;
      end
      if (hit(paddr, CSCRU_SLOW_IDX))
        slow_r <= {2'b00, wb[5:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      realtime_interrupt_control_r  <= 8'h00;
      copctl_r  <= CSCRU_COPCTL_RST;
      swai_wr_r <= 1'b0;
      wcop_wr_r <= 1'b0;
    end else if (wr && pready) begin
      if (hit(paddr, CSCRU_REALTIME_INTERRUPT_CONTROL_IDX)) begin
        realtime_interrupt_control_r[CSCRU_PERIODIC_IRQ_ENABLE_BIT] <= wb[7];
        realtime_interrupt_control_r[2:0]            <= wb[2:0];
        if (special_mode || !swai_wr_r) begin
          realtime_interrupt_control_r[CSCRU_SWAI_BIT] <= wb[6];
          swai_wr_r <= 1'b1;
        end
      end
      if (hit(paddr, CSCRU_COPCTL_IDX)) begin
        copctl_r[CSCRU_CME_BIT] <= wb[7];
        copctl_r[2:0]           <= wb[2:0];
        if (special_mode || !wcop_wr_r) begin
          copctl_r[CSCRU_WCOP_BIT] <= wb[4];
          wcop_wr_r <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // slow divider and clock chain
  // ------------------------------------------------------------------
  logic slow_en;

  cscru_slow_div u_slow (
    .pclk     (pclk),
    .presetn  (presetn),
    .xtal_en  (xtal_en),
    .div_val  (slow_r[5:0]),
    .slow_en  (slow_en),
    .slow_lvl ()
  );

  // glitch-free switch: stop output, settle, then release
  logic [1:0] src_cur_r, src_req;
  logic [2:0] sw_cnt_r;

  always_comb begin
    if (limp_home || clock_source_select_r[CSCRU_PLL_SELECT_BIT])
      src_req = 2'h2;
    else if (clock_source_select_r[CSCRU_SLOW_SELECT_BIT])
      src_req = 2'h1;
    else
      src_req = 2'h0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_cur_r     <= 2'h0;
      sw_cnt_r      <= 3'h0;
      clk_select_ok <= 1'b1;
    end else if (src_req != src_cur_r) begin
      clk_select_ok <= 1'b0;
      sw_cnt_r      <= sw_cnt_r + 3'h1;
      if (sw_cnt_r == 3'(CSCRU_SWITCH_CYC - 1)) begin
        src_cur_r <= src_req;
        sw_cnt_r  <= 3'h0;
      end
    end else begin
      clk_select_ok <= 1'b1;
      sw_cnt_r      <= 3'h0;
    end
  end

  logic sys_en, half_sys_r, half_slow_r, half_xtal_r, ref_en, mclk;

  assign sys_en = clk_select_ok &&
                  (src_cur_r == 2'h2 ? pll_en :
                   src_cur_r == 2'h1 ? slow_en : xtal_en);
  assign ref_en = limp_home ? pll_en : slow_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_sys_r  <= 1'b0;
      half_slow_r <= 1'b0;
      half_xtal_r <= 1'b0;
    end else begin
      if (sys_en) half_sys_r <= ~half_sys_r;
      if (ref_en) half_slow_r <= ~half_slow_r;
      if (limp_home ? pll_en : xtal_en) half_xtal_r <= ~half_xtal_r;
    end
  end

  logic e_en, x_en;
  assign e_en = sys_en && half_sys_r;
  assign x_en = ref_en && half_slow_r;
  assign mclk = mcs_eff ? x_en : e_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_en      <= '0;
      pll_sel_eff <= 1'b0;
      mcs_eff     <= 1'b0;
    end else begin
      pll_sel_eff <= limp_home | clock_source_select_r[CSCRU_PLL_SELECT_BIT];
      mcs_eff     <= !limp_home && clock_source_select_r[CSCRU_MCS_BIT];
      clk_en.system_clock       <= sys_en;
      clk_en.e_clock            <= e_en;
      clk_en.periph_clock       <= e_en;
      clk_en.module_clock       <= mclk;
      clk_en.slow_derived_clock <= x_en;
      clk_en.can_clock          <= clock_source_select_r[CSCRU_CANSRC_BIT] ? sys_en
                                                              : xtal_en;
      clk_en.debug_clock        <= clock_source_select_r[CSCRU_DBGSW_BIT] ? e_en
                                   : (xtal_en && half_xtal_r);
    end
  end

  // ------------------------------------------------------------------
  // clock monitor and limp home
  // ------------------------------------------------------------------
  logic [15:0] cm_cnt_r;
  logic        cm_fail;
  assign cm_fail = (cm_cnt_r >= 16'(CM_CYC));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cm_cnt_r <= 16'h0000;
    else if (xtal_en) cm_cnt_r <= 16'h0000;
    else if (!cm_fail) cm_cnt_r <= cm_cnt_r + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limp_home <= 1'b0;
      lh_flag_r <= 1'b0;
      limp_irq  <= 1'b0;
    end else begin
      limp_home <= cm_fail && !pllcr_r[CSCRU_NOLH_BIT];
      if (limp_home != (cm_fail && !pllcr_r[CSCRU_NOLH_BIT]))
        lh_flag_r <= 1'b1;
      limp_irq <= lh_flag_r && pllcr_r[CSCRU_LIMP_HOME_IRQ_ENABLE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_bw_low       <= 1'b0;
      osc_keep_in_stop <= 1'b0;
    end else begin
      pll_bw_low       <= pllcr_r[CSCRU_ACQ_BIT];
      osc_keep_in_stop <= pllcr_r[CSCRU_PSEUDO_STOP_ENABLE_BIT];
    end
  end

  // ------------------------------------------------------------------
  // periodic interrupt and watchdog on slow-derived clock
  // ------------------------------------------------------------------
  logic [23:0] rti_cnt_r, wd_cnt_r;
  logic        run, rti_tick, wd_to, wd_win;
  logic [4:0]  wd_exp;

  function automatic logic [4:0] wd_log2(input logic [2:0] r);
    unique case (r)
      3'h1: wd_log2 = 5'd13;
      3'h2: wd_log2 = 5'd15;
      3'h3: wd_log2 = 5'd17;
      3'h4: wd_log2 = 5'd19;
      3'h5: wd_log2 = 5'd21;
      3'h6: wd_log2 = 5'd22;
      3'h7: wd_log2 = 5'd23;
      default: wd_log2 = 5'd0;
    endcase
  endfunction : wd_log2

  assign run    = x_en && !(cpu_in_wait && realtime_interrupt_control_r[CSCRU_SWAI_BIT]);
  assign rti_tick = (realtime_interrupt_control_r[2:0] != 3'h0) && run &&
                    (rti_cnt_r == (24'h1 << (5'd12 + 5'(realtime_interrupt_control_r[2:0])))
                                  - 24'h1);
  assign wd_exp = wd_log2(copctl_r[2:0]);
  assign wd_to  = (wd_exp != 5'd0) && (wd_cnt_r == (24'hffffff >>
                  (5'd24 - wd_exp)));
  // three quarters as whole minus quarter: 3 << 23 would not fit
  assign wd_win = wd_cnt_r >= ((24'h1 << wd_exp) -
                               (24'h1 << (wd_exp - 5'd2)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rti_cnt_r <= 24'h0;
    else if (rti_tick) rti_cnt_r <= 24'h0;
    else if (realtime_interrupt_control_r[2:0] == 3'h0) rti_cnt_r <= 24'h0;
    else if (run) rti_cnt_r <= rti_cnt_r + 24'h1;
  end

  // set beats a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) periodic_irq_flag_r <= 1'b0;
    else if (rti_tick) periodic_irq_flag_r <= 1'b1;
    else if (wr && pready && hit(paddr, CSCRU_RTIFLG_IDX) && wb[7])
      periodic_irq_flag_r <= 1'b0;
  end

  logic svc_wr, svc_bad;
  assign svc_wr  = wr && pready && hit(paddr, CSCRU_WDSVC_IDX) &&
                   wd_exp != 5'd0;
  assign svc_bad = svc_wr && ((wb != CSCRU_SVC_FIRST &&
                   wb != CSCRU_SVC_SECOND) ||
                   (copctl_r[CSCRU_WCOP_BIT] && !wd_win));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_r    <= 24'h0;
      svc_armed_r <= 1'b0;
    end else if (wd_exp == 5'd0) begin
      // held at zero while off, so enabling starts a full period
      wd_cnt_r    <= 24'h0;
      svc_armed_r <= 1'b0;
    end else if (svc_wr && wb == CSCRU_SVC_SECOND && svc_armed_r) begin
      wd_cnt_r    <= 24'h0;
      svc_armed_r <= 1'b0;
    end else begin
      if (svc_wr && wb == CSCRU_SVC_FIRST) svc_armed_r <= 1'b1;
      if (run && !wd_to) wd_cnt_r <= wd_cnt_r + 24'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      part_reset   <= 1'b0;
      periodic_irq <= 1'b0;
    end else begin
      part_reset <= svc_bad || wd_to ||
                    (cm_fail && copctl_r[CSCRU_CME_BIT] &&
                     pllcr_r[CSCRU_NOLH_BIT]);
      periodic_irq <= periodic_irq_flag_r && realtime_interrupt_control_r[CSCRU_PERIODIC_IRQ_ENABLE_BIT];
    end
  end

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (rd) begin
      unique case (paddr)
        {CSCRU_REALTIME_INTERRUPT_CONTROL_IDX[9:0], 2'b00}: prdata <= {24'h0, realtime_interrupt_control_r};
        {CSCRU_RTIFLG_IDX[9:0], 2'b00}: prdata <= {24'h0, periodic_irq_flag_r, 7'h00};
        {CSCRU_COPCTL_IDX[9:0], 2'b00}: prdata <= {24'h0, copctl_r};
        {CSCRU_PLLCR_IDX[9:0], 2'b00}:  prdata <= {24'h0, pllcr_r};
        {CSCRU_CLOCK_SOURCE_SELECT_IDX[9:0], 2'b00}: prdata <= {24'h0, clock_source_select_r};
        {CSCRU_SLOW_IDX[9:0], 2'b00}:   prdata <= {24'h0, slow_r};
        {CSCRU_MODE_IDX[9:0], 2'b00}:
          prdata <= {24'h0, 6'h00, limp_home, lh_flag_r};
        default:          prdata <= 32'h0;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_pll_refused: assert property (@(posedge pclk) disable iff (!presetn)
    !pllcr_r[CSCRU_PLL_POWER_ON_BIT] && !$past(pllcr_r[CSCRU_PLL_POWER_ON_BIT]) &&
    !$past(clock_source_select_r[CSCRU_PLL_SELECT_BIT])
    |-> !clock_source_select_r[CSCRU_PLL_SELECT_BIT]) else $error("pll select set");
  a_limp_forces: assert property (@(posedge pclk) disable iff (!presetn)
    $past(limp_home) |-> pll_sel_eff && !mcs_eff)
    else $error("limp home not forcing selects");
  a_supply_force: assert property (@(posedge pclk) disable iff (!presetn)
    $past(!pll_supply_good) |-> pllcr_r[0] && !pllcr_r[1])
    else $error("supply forces missing");
  a_periodic_irq_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
    rti_tick |=> periodic_irq_flag_r) else $error("periodic flag not set");
  a_svc_bad: assert property (@(posedge pclk) disable iff (!presetn)
    svc_wr && wb != CSCRU_SVC_FIRST && wb != CSCRU_SVC_SECOND
    |=> part_reset)
    else $error("bad service value no reset");
  a_switch_low: assert property (@(posedge pclk) disable iff (!presetn)
    src_req != src_cur_r |=> !clk_select_ok)
    else $error("select not held low");
  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !realtime_interrupt_control_r[7] |=> !periodic_irq) else $error("irq not gated");
  a_slow_value: assert property (@(posedge pclk) disable iff (!presetn)
    xtal_en && slow_r[5:0] == 6'h00 |=> slow_en)
    else $error("slow divider not bypassed");

endmodule : cscru_top

/* hdl/cscru_pkg.sv */
// package: register map, fields and constants of the clock select unit
package cscru_pkg;

  // --------------------------------------------------------------------
  // register indices (byte address is four times the index, one aligned word each on apb)
  // --------------------------------------------------------------------
  localparam logic [11:0] CSCRU_REALTIME_INTERRUPT_CONTROL_IDX  = 12'h014;
  localparam logic [11:0] CSCRU_RTIFLG_IDX  = 12'h015;
  localparam logic [11:0] CSCRU_COPCTL_IDX  = 12'h016;
  localparam logic [11:0] CSCRU_WDSVC_IDX   = 12'h017;
  localparam logic [11:0] CSCRU_PLLCR_IDX   = 12'h03c;
  localparam logic [11:0] CSCRU_CLOCK_SOURCE_SELECT_IDX  = 12'h03d;
  localparam logic [11:0] CSCRU_SLOW_IDX    = 12'h03e;
  localparam logic [11:0] CSCRU_MODE_IDX    = 12'h03f;

  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int CSCRU_PERIODIC_IRQ_ENABLE_BIT    = 7;
  localparam int CSCRU_SWAI_BIT    = 6;
  localparam int CSCRU_PERIODIC_IRQ_FLAG_BIT    = 7;
  localparam int CSCRU_CME_BIT     = 7;
  localparam int CSCRU_WCOP_BIT    = 4;
  localparam int CSCRU_PLL_POWER_ON_BIT   = 6;
  localparam int CSCRU_AUTO_BIT    = 5;
  localparam int CSCRU_ACQ_BIT     = 4;
  localparam int CSCRU_PSEUDO_STOP_ENABLE_BIT    = 2;
  localparam int CSCRU_LIMP_HOME_IRQ_ENABLE_BIT    = 1;
  localparam int CSCRU_NOLH_BIT    = 0;
  localparam int CSCRU_PLL_SELECT_BIT    = 6;
  localparam int CSCRU_SLOW_SELECT_BIT    = 5;
  localparam int CSCRU_MCS_BIT     = 2;
  localparam int CSCRU_CANSRC_BIT  = 1;
  localparam int CSCRU_DBGSW_BIT   = 0;

  // --------------------------------------------------------------------
  // reset values and constants
  // --------------------------------------------------------------------
  localparam logic [7:0] CSCRU_PLLCR_RST  = 8'h60;
  localparam logic [7:0] CSCRU_COPCTL_RST = 8'h07;
  localparam logic [7:0] CSCRU_SVC_FIRST  = 8'h55;
  localparam logic [7:0] CSCRU_SVC_SECOND = 8'haa;
  localparam int         CSCRU_SWITCH_CYC = 4;
  localparam int         CSCRU_CLK_NS     = 100;
  localparam int         CSCRU_CM_MIN_NS  = 2000;
  localparam int         CSCRU_CM_CYC     = (CSCRU_CM_MIN_NS + CSCRU_CLK_NS - 1)
                                            / CSCRU_CLK_NS;

  typedef struct packed {
    logic system_clock;
    logic e_clock;
    logic periph_clock;
    logic module_clock;
    logic slow_derived_clock;
    logic can_clock;
    logic debug_clock;
  } cscru_clk_s;

endpackage : cscru_pkg

/* hdl/cscru_slow_div.sv */
// slow divider: crystal enable divided by twice the programmed value
module cscru_slow_div
  import cscru_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       xtal_en,
  input  wire logic [5:0] div_val,
  // output
  output logic            slow_en,
  output logic            slow_lvl
);

  logic [5:0] cnt_r;

  // restart on terminal count also clamps a shrunk value at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r    <= 6'h00;
      slow_lvl <= 1'b0;
      slow_en  <= 1'b0;
    end else begin
      slow_en <= 1'b0;
      if (xtal_en) begin
        if (div_val == 6'h00) begin
          slow_en  <= 1'b1;
          slow_lvl <= ~slow_lvl;
          cnt_r    <= 6'h00;
        end else if (cnt_r + 6'h01 >= div_val) begin
          cnt_r    <= 6'h00;
          slow_lvl <= ~slow_lvl;
          slow_en  <= slow_lvl;
        end else begin
          cnt_r <= cnt_r + 6'h01;
        end
      end
    end
  end

endmodule : cscru_slow_div

/* dv/cscru_src_model.sv */
// crystal and pll source model: edge enables for the clock select unit
module cscru_src_model #(
  parameter int XDIV = 1
)(
  // clock
  input  wire logic pclk,
  // control
  input  wire logic xtal_run,
  // edges
  output logic      xtal_en,
  output logic      pll_en
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;

  always @(posedge pclk) begin
    cnt <= (cnt + 1 >= XDIV) ? 0 : cnt + 1;
  end

  // a lost crystal gives no edges at all, not a stuck level
  assign xtal_en = xtal_run && (cnt == 0);
  assign pll_en  = 1'b1;
endmodule : cscru_src_model

/* dv/tb_top.sv */
// testbench for the clock select unit over apb
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cscru_pkg::*;

  // --------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        locked = 1'b0, supply = 1'b1, special = 1'b1;
  logic        in_wait = 1'b0, xrun = 1'b1;
  logic [31:0] prdata;
  logic        pready, pslverr, sel_ok, limp, psel_eff, mcs_eff;
  logic        bw_low, osc_keep, limp_irq, per_irq, prst;
  logic        xtal_en, pll_en;
  cscru_clk_s  clk_en;
  int          n_errors = 0, comparisons = 0, n_rst = 0, c, k;
  logic [7:0]  rd;
  logic [7:0]  cs_t [7] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h00, 8'h20, 8'h60};
  logic [7:0]  sl_t [7] = '{8'h00, 8'h01, 8'h03, 8'h3f, 8'h03, 8'h03, 8'h03};

  always #50 pclk = ~pclk;
  always @(posedge pclk) if (prst === 1'b1) n_rst++;

  cscru_src_model src (.pclk(pclk), .xtal_run(xrun), .xtal_en(xtal_en),
                       .pll_en(pll_en));

  cscru_top #(.CM_CYC(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xtal_en(xtal_en), .pll_en(pll_en),
    .pll_locked(locked), .pll_supply_good(supply), .special_mode(special),
    .cpu_in_wait(in_wait), .clk_en(clk_en), .clk_select_ok(sel_ok),
    .limp_home(limp), .pll_sel_eff(psel_eff), .mcs_eff(mcs_eff),
    .pll_bw_low(bw_low), .osc_keep_in_stop(osc_keep), .limp_irq(limp_irq),
    .periodic_irq(per_irq), .part_reset(prst));

  // --------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------
  task stop_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // a is the register index; the byte address is four times it
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a[9:0], 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata[7:0];
    chk({7'h00, pslverr}, 8'h00);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rdc(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
    apb(1'b0, a, 8'h00);
    chk(rd & m, e);
  endtask : rdc

  function automatic logic cond(input int w);
    case (w)
      0: return sel_ok === 1'b0;
      1: return limp === 1'b1;
      2: return per_irq === 1'b1;
      3: return clk_en.e_clock === 1'b1;
      5: return clk_en.can_clock === 1'b1;
      6: return clk_en.debug_clock === 1'b1;
      default: return clk_en.module_clock === 1'b1;
    endcase
  endfunction : cond

  // cycles until the condition holds, n if it never does
  task wt(input int w, input int n, output int cnt);
    cnt = 0;
    do begin @(posedge pclk); cnt++; end while (!cond(w) && cnt < n);
  endtask : wt

  task do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  // --------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------
  initial begin
    do_reset;
    rdc(CSCRU_CLOCK_SOURCE_SELECT_IDX, 8'h00, 8'hff);
    rdc(CSCRU_SLOW_IDX, 8'h00, 8'hff);
    rdc(CSCRU_PLLCR_IDX, CSCRU_PLLCR_RST, 8'hff);
    rdc(CSCRU_COPCTL_IDX, CSCRU_COPCTL_RST, 8'hff);
    rdc(12'h020, 8'h00, 8'hff);
    for (int i = 0; i < 7; i++) begin
      wr(CSCRU_CLOCK_SOURCE_SELECT_IDX, cs_t[i]);
      wr(CSCRU_SLOW_IDX, sl_t[i]);
      // the first period may still be the old ratio
      wt(cs_t[i] == 8'h04 ? 4 : 3, 600, c);
      wt(cs_t[i] == 8'h04 ? 4 : 3, 600, c);
      wt(cs_t[i] == 8'h04 ? 4 : 3, 600, c);
      k = (cs_t[i] == 8'h00 || cs_t[i] == 8'h60) ? 2 :
          (sl_t[i] == 8'h00 ? 2 : 4 * sl_t[i]);
      chk(c[7:0], k[7:0]);
    end
    wr(CSCRU_CLOCK_SOURCE_SELECT_IDX, 8'h03);
    wt(0, 10, c);
    chk(c < 10, 1'b1);
    wt(6, 600, c);
    wt(6, 600, c);
    chk(c[7:0], 8'h02);
    wt(5, 600, c);
    wt(5, 600, c);
    chk(c[7:0], 8'h01);
    wr(CSCRU_PLLCR_IDX, 8'h20);
    wr(CSCRU_CLOCK_SOURCE_SELECT_IDX, 8'h40);
    rdc(CSCRU_CLOCK_SOURCE_SELECT_IDX, 8'h00, 8'hff);
    chk(psel_eff, 1'b0);
    wr(CSCRU_PLLCR_IDX, 8'h54);
    repeat (2) @(posedge pclk);
    chk({bw_low, osc_keep}, 2'b11);
    wr(CSCRU_PLLCR_IDX, 8'h40);
    repeat (2) @(posedge pclk);
    chk({bw_low, osc_keep}, 2'b00);
    locked <= 1'b1;
    wr(CSCRU_PLLCR_IDX, 8'h60);
    repeat (4) @(posedge pclk);
    rdc(CSCRU_PLLCR_IDX, 8'h10, 8'h10);
    locked <= 1'b0;
    repeat (4) @(posedge pclk);
    rdc(CSCRU_PLLCR_IDX, 8'h00, 8'h10);
    supply <= 1'b0;
    wr(CSCRU_PLLCR_IDX, 8'h62);
    rdc(CSCRU_PLLCR_IDX, 8'h01, 8'h43);
    supply <= 1'b1;
    do_reset;
    wr(CSCRU_COPCTL_IDX, 8'h80);
    wr(CSCRU_CLOCK_SOURCE_SELECT_IDX, 8'h04);
    wr(CSCRU_PLLCR_IDX, 8'h62);
    k = n_rst;
    xrun <= 1'b0;
    wt(1, 40, c);
    chk(c < 40, 1'b1);
    @(posedge pclk);
    chk({psel_eff, mcs_eff}, 2'b10);
    chk(limp_irq, 1'b1);
    rdc(CSCRU_CLOCK_SOURCE_SELECT_IDX, 8'h04, 8'hff);
    wt(4, 600, c);
    wt(4, 600, c);
    chk(c < 600, 1'b1);
    chk(n_rst == k, 1'b1);
    xrun <= 1'b1;
    special <= 1'b0;
    do_reset;
    wr(CSCRU_PLLCR_IDX, 8'h61);
    wr(CSCRU_PLLCR_IDX, 8'h60);
    rdc(CSCRU_PLLCR_IDX, 8'h01, 8'h01);
    wr(CSCRU_REALTIME_INTERRUPT_CONTROL_IDX, 8'h40);
    wr(CSCRU_REALTIME_INTERRUPT_CONTROL_IDX, 8'h00);
    rdc(CSCRU_REALTIME_INTERRUPT_CONTROL_IDX, 8'h40, 8'h40);
    wr(CSCRU_COPCTL_IDX, 8'h80);
    k = n_rst;
    xrun <= 1'b0;
    repeat (40) @(posedge pclk);
    chk(n_rst > k, 1'b1);
    chk(limp, 1'b0);
    xrun <= 1'b1;
    special <= 1'b1;
    do_reset;
    wr(CSCRU_COPCTL_IDX, 8'h01);
    k = n_rst;
    wr(CSCRU_WDSVC_IDX, CSCRU_SVC_FIRST);
    wr(CSCRU_WDSVC_IDX, CSCRU_SVC_SECOND);
    repeat (10) @(posedge pclk);
    chk(n_rst == k, 1'b1);
    wr(CSCRU_WDSVC_IDX, 8'h33);
    repeat (10) @(posedge pclk);
    chk(n_rst > k, 1'b1);
    wr(CSCRU_COPCTL_IDX, 8'h11);
    k = n_rst;
    wr(CSCRU_WDSVC_IDX, CSCRU_SVC_FIRST);
    repeat (10) @(posedge pclk);
    chk(n_rst > k, 1'b1);
    wr(CSCRU_COPCTL_IDX, 8'h00);
    wr(CSCRU_REALTIME_INTERRUPT_CONTROL_IDX, 8'h81);
    wt(2, 17000, c);
    rdc(CSCRU_RTIFLG_IDX, 8'h80, 8'h80);
    wr(CSCRU_RTIFLG_IDX, 8'h80);
    repeat (2) @(posedge pclk);
    chk(per_irq, 1'b0);
    wt(2, 17000, c);
    // 2^13 slow-derived edges of two cycles, less the clearing access
    chk(c > 16370 && c < 16390, 1'b1);
    stop_test;
  end

  initial begin
    #(100 * 60000);
    n_errors++;
    stop_test;
  end
endmodule : tb_top
